// ===== vpec_pkg.sv
// What this block does
// - With the preset-select pin low, enable permit, voltage code and forced-PWM come from 0x11 and the low bit of 0x14.
// - With the preset-select pin high, enable permit, voltage code and forced-PWM come from 0x10 and the high bit of 0x14.
// - The converter turns on from a high enable pin only while the selected enable permit is 1.
// - While the selected enable permit is 0 the converter stays off whatever the enable pin does.
// - A latched protection shutdown clears only on an enable pin toggle or a re-power of the analog supply.
// - The I2C target keeps answering while the enable pin is low and the converter is off.
// - No register returns to its default while the converter is off because of a low enable pin.
// - The I2C target works at bus rates up to fast mode and the host stays at or below it.
// - After power-up the voltage codes mean 2.8 V for the high preset and 1 V for the low preset.
// - The output setting is split into four banks that together span 0.3 V to 5.5 V.
// - Ramped scaling applies only inside one bank and a bank change jumps straight to the new setting.
// - Programmable upper and lower limits bound the output voltage code.
// - Each preset chooses automatic pulse-skip/PWM or forced PWM by its own mode bit.
// - Inside one bank the reference steps gradually, one code step per ramp interval.
// - A change on the preset-select pin switches the preset at once with no bus transaction.
package vpec_pkg;
    // Register offsets.
    localparam logic [7:0] REG_HIGH_PRESET = 8'h10;
    localparam logic [7:0] REG_LOW_PRESET = 8'h11;
    localparam logic [7:0] REG_PWM_MODE = 8'h14;
    localparam logic [7:0] REG_BANK = 8'h15;
    localparam logic [7:0] REG_VMAX = 8'h16;
    localparam logic [7:0] REG_VMIN = 8'h17;
    localparam logic [7:0] REG_OC_LEVEL = 8'h1A;
    localparam logic [7:0] REG_STATUS = 8'h1B;
    // Field positions.
    localparam int PERMIT_BIT = 7;
    localparam int PWM_LOW_BIT = 0;
    localparam int PWM_HIGH_BIT = 1;
    localparam int BANK_LOW_LSB = 0;
    localparam int BANK_HIGH_LSB = 2;
    // Reset values: bank 2 top code is 2.8 V, bank 1 mid code is 1 V.
    localparam logic [7:0] RST_HIGH_PRESET = 8'h00_FF;
    localparam logic [7:0] RST_LOW_PRESET = 8'h00_C0;
    localparam logic [7:0] RST_PWM_MODE = 8'h00_00;
    localparam logic [7:0] RST_BANK = 8'h00_09;
    localparam logic [7:0] RST_VMAX = 8'h00_7F;
    localparam logic [7:0] RST_VMIN = 8'h00_00;
    localparam logic [7:0] RST_OC_LEVEL = 8'h00_04;
    // Target address, an arbitrary value.
    localparam logic [6:0] DEV_ADDR = 7'h1C;
    // Ramp timing: one code step per interval.
    localparam int CLK_PERIOD_NS = 5;
    localparam int RAMP_STEP_NS = 10000;
    localparam int RAMP_CYCLES = RAMP_STEP_NS / CLK_PERIOD_NS;
    localparam logic [11:0] RAMP_LAST = 12'(RAMP_CYCLES - 1);
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Bus engine states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b011,
        ST_WR = 3'b010,
        ST_RD = 3'b110,
        ST_RACK = 3'b111
    } vpec_state_t;
endpackage

// ===== vpec_core.sv
`timescale 1ns/1ps
module vpec_core
    import vpec_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Converter control pins.
    input wire logic presetSelectPin,
    input wire logic enablePin,
    input wire logic protectFault,
    // I2C target pins.
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_b,
    // Converter controls.
    output logic convEnable,
    output logic forcedPwm,
    output logic [6:0] voutTarget,
    output logic [1:0] voutBank,
    output logic [7:0] overcurrentLimit,
    output logic protLatched
);
    // Clamps a code into the programmed window.
    function automatic logic [6:0] clampCode(input logic [6:0] c, input logic [6:0] lo,
                                             input logic [6:0] hi);
        if (c > hi)
            return hi;
        else if (c < lo)
            return lo;
        else
            return c;
    endfunction

    // Register file.
    logic [7:0] highPreset_r;
    logic [7:0] lowPreset_r;
    logic [7:0] pwmMode_r;
    logic [7:0] bankSel_r;
    logic [7:0] vmax_r;
    logic [7:0] vmin_r;
    logic [7:0] ocLevel_r;
    // Bus engine state.
    vpec_state_t state_r;
    logic [7:0] shReg_r;
    logic [2:0] bitCnt_r;
    logic [7:0] ptr_r;
    logic firstByte_r;
    logic rwBit_r;
    logic ackSeen_r;
    logic sclQ_r;
    logic sdaQ_r;
    logic wrStb;
    logic [7:0] wrByte;
    // Converter state.
    logic enPinQ_r;
    logic [6:0] refCode_r;
    logic [1:0] refBank_r;
    logic [11:0] rampCnt_r;

    // Pin edges and bus conditions; inputs are synchronous to the clock.
    wire sclRise = scl & ~sclQ_r;
    wire sclFall = ~scl & sclQ_r;
    wire startCond = scl & sclQ_r & sdaQ_r & ~sdaIn;
    wire stopCond = scl & sclQ_r & ~sdaQ_r & sdaIn;
    wire lastBit = (bitCnt_r == BIT_LAST);
    wire [7:0] shNext = {shReg_r[6:0], sdaIn};

    // Preset multiplexer driven straight by the pin.
    wire selHigh = presetSelectPin;
    wire [7:0] selPreset = selHigh ? highPreset_r : lowPreset_r;
    wire selPermit = selPreset[PERMIT_BIT];
    wire selPwm = selHigh ? pwmMode_r[PWM_HIGH_BIT] : pwmMode_r[PWM_LOW_BIT];
    wire [1:0] selBank = selHigh ? bankSel_r[BANK_HIGH_LSB +: 2] : bankSel_r[BANK_LOW_LSB +: 2];
    wire [6:0] selCode = clampCode(selPreset[6:0], vmin_r[6:0], vmax_r[6:0]);
    wire rampTick = (rampCnt_r == RAMP_LAST);
    wire ramping = (refCode_r != selCode) & (refBank_r == selBank);
    wire enFall = enPinQ_r & ~enablePin;

    // Read mux; unmapped offsets read as zero.
    wire [7:0] statusByte = {4'h0, presetSelectPin, ramping, protLatched, convEnable};
    wire [7:0] rdData =
        (ptr_r == REG_HIGH_PRESET) ? highPreset_r :
        (ptr_r == REG_LOW_PRESET) ? lowPreset_r :
        (ptr_r == REG_PWM_MODE) ? pwmMode_r :
        (ptr_r == REG_BANK) ? bankSel_r :
        (ptr_r == REG_VMAX) ? vmax_r :
        (ptr_r == REG_VMIN) ? vmin_r :
        (ptr_r == REG_OC_LEVEL) ? ocLevel_r :
        (ptr_r == REG_STATUS) ? statusByte : 8'h00_00;

    // Write strobe for a completed data byte after the pointer byte.
    assign wrStb = (state_r == ST_WR) & sclRise & lastBit & ~firstByte_r;
    assign wrByte = shNext;

    // Pin sampling for edge detection.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclQ_r <= 1'b1;
            sdaQ_r <= 1'b1;
            enPinQ_r <= 1'b0;
        end
        else if (clkEn)
        begin
            sclQ_r <= scl;
            sdaQ_r <= sdaIn;
            enPinQ_r <= enablePin;
        end
    end

    // Registers reset only with the analog supply, never by the enable pin.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            highPreset_r <= RST_HIGH_PRESET;
            lowPreset_r <= RST_LOW_PRESET;
            pwmMode_r <= RST_PWM_MODE;
            bankSel_r <= RST_BANK;
            vmax_r <= RST_VMAX;
            vmin_r <= RST_VMIN;
            ocLevel_r <= RST_OC_LEVEL;
        end
        else if (clkEn && wrStb)
        begin
            if (ptr_r == REG_HIGH_PRESET)
                highPreset_r <= wrByte;
            if (ptr_r == REG_LOW_PRESET)
                lowPreset_r <= wrByte;
            if (ptr_r == REG_PWM_MODE)
                pwmMode_r <= wrByte;
            if (ptr_r == REG_BANK)
                bankSel_r <= wrByte;
            if (ptr_r == REG_VMAX)
                vmax_r <= wrByte;
            if (ptr_r == REG_VMIN)
                vmin_r <= wrByte;
            if (ptr_r == REG_OC_LEVEL)
                ocLevel_r <= wrByte;
        end
    end

    // I2C target engine; it runs regardless of the enable pin.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            shReg_r <= 8'h00_00;
            bitCnt_r <= 3'h0;
            ptr_r <= 8'h00_00;
            firstByte_r <= 1'b0;
            rwBit_r <= 1'b0;
            ackSeen_r <= 1'b0;
            sdaOe_b <= 1'b1;
            sdaOut <= 1'b0;
        end
        else if (clkEn)
        begin
            sdaOut <= 1'b0;
            if (startCond)
            begin
                state_r <= ST_ADDR;
                bitCnt_r <= 3'h0;
                firstByte_r <= 1'b1;
                ackSeen_r <= 1'b0;
                sdaOe_b <= 1'b1;
            end
            else if (stopCond)
            begin
                state_r <= ST_IDLE;
                sdaOe_b <= 1'b1;
            end
            else
            begin
                unique case (state_r)
                    ST_IDLE:
                        sdaOe_b <= 1'b1;
                    ST_ADDR:
                        if (sclRise)
                        begin
                            shReg_r <= shNext;
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (lastBit)
                            begin
                                rwBit_r <= sdaIn;
                                state_r <= (shReg_r[6:0] == DEV_ADDR) ? ST_ACK : ST_IDLE;
                            end
                        end
                    ST_ACK:
                        if (sclRise)
                            ackSeen_r <= 1'b1;
                        else if (sclFall && !ackSeen_r)
                            sdaOe_b <= 1'b0;
                        else if (sclFall)
                        begin
                            ackSeen_r <= 1'b0;
                            if (rwBit_r)
                            begin
                                state_r <= ST_RD;
                                shReg_r <= rdData;
                                sdaOe_b <= rdData[7];
                            end
                            else
                            begin
                                state_r <= ST_WR;
                                sdaOe_b <= 1'b1;
                            end
                        end
                    ST_WR:
                        if (sclRise)
                        begin
                            shReg_r <= shNext;
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (lastBit)
                            begin
                                state_r <= ST_ACK;
                                firstByte_r <= 1'b0;
                                ptr_r <= firstByte_r ? shNext : ptr_r + 8'h01;
                            end
                        end
                    ST_RD:
                        if (sclRise)
                        begin
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (lastBit)
                            begin
                                state_r <= ST_RACK;
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                        else if (sclFall)
                        begin
                            shReg_r <= {shReg_r[6:0], 1'b0};
                            sdaOe_b <= shReg_r[6];
                        end
                    ST_RACK:
                        if (sclRise)
                            ackSeen_r <= ~sdaIn;
                        else if (sclFall && !ackSeen_r)
                            sdaOe_b <= 1'b1;
                        else if (sclFall)
                        begin
                            ackSeen_r <= 1'b0;
                            state_r <= ST_RD;
                            shReg_r <= rdData;
                            sdaOe_b <= rdData[7];
                        end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Protection latch; a new fault wins over a clear in the same cycle.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            protLatched <= 1'b0;
        else if (clkEn)
            protLatched <= protectFault | (protLatched & ~enFall);
    end

    // Enable gate and mode taken from the live preset mux.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            convEnable <= 1'b0;
            forcedPwm <= 1'b0;
            overcurrentLimit <= RST_OC_LEVEL;
        end
        else if (clkEn)
        begin
            convEnable <= enablePin & selPermit & ~protLatched & ~protectFault;
            forcedPwm <= selPwm;
            overcurrentLimit <= ocLevel_r;
        end
    end

    // Reference ramp: steps inside a bank, jumps on a bank change.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rampCnt_r <= 12'h000;
            refCode_r <= RST_LOW_PRESET[6:0];
            refBank_r <= RST_BANK[BANK_LOW_LSB +: 2];
        end
        else if (clkEn)
        begin
            rampCnt_r <= rampTick ? 12'h000 : rampCnt_r + 12'h001;
            if (refBank_r != selBank)
            begin
                refBank_r <= selBank;
                refCode_r <= selCode;
            end
            else if (rampTick && refCode_r < selCode)
                refCode_r <= refCode_r + 7'h01;
            else if (rampTick && refCode_r > selCode)
                refCode_r <= refCode_r - 7'h01;
        end
    end

    // Bank and target come straight from the reference flops.
    assign voutTarget = refCode_r;
    assign voutBank = refBank_r;
endmodule

// ===== vpec_core_checker.sv
`timescale 1ns/1ps
module vpec_core_checker
(
    // Clock, reset and enable.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Control pins.
    input wire logic presetSelectPin,
    input wire logic enablePin,
    input wire logic protectFault,
    // Bus pins.
    input wire logic scl,
    input wire logic sdaOut,
    input wire logic sdaOe_b,
    // Converter controls.
    input wire logic convEnable,
    input wire logic forcedPwm,
    input wire logic [6:0] voutTarget,
    input wire logic [1:0] voutBank,
    input wire logic [7:0] overcurrentLimit,
    input wire logic protLatched
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // The converter runs only from a high pin with no fault pending.
    AST_CONV_GATE: assert property ($past(clkEn) && convEnable |->
        $past(enablePin) && !$past(protectFault) && !$past(protLatched))
        else $error("converter on without cause");
    // A fault sets the latch on the next cycle.
    AST_FAULT_SET: assert property (clkEn && protectFault |=> protLatched)
        else $error("fault not latched");
    // Without a pin toggle the latch stays set.
    AST_LATCH_HOLD: assert property (clkEn && protLatched && !($past(enablePin) && !enablePin)
        |=> protLatched)
        else $error("latch cleared without toggle");
    // A falling enable pin clears the latch when no fault is present.
    AST_LATCH_CLEAR: assert property (clkEn && protLatched && $past(enablePin) && !enablePin
        && !protectFault |=> !protLatched)
        else $error("latch kept after toggle");
    // Within one bank the target moves one code step at a time.
    AST_RAMP_STEP: assert property ($stable(voutBank) && $changed(voutTarget) |->
        voutTarget == $past(voutTarget) + 7'h1 || voutTarget == $past(voutTarget) - 7'h1)
        else $error("target jumped inside bank");
    // SDA drive changes only one cycle after an SCL falling sample.
    AST_SDA_TIMING: assert property ($changed(sdaOe_b) |->
        $past(clkEn) && !$past(scl) && $past(scl, 2))
        else $error("sda drive changed off the scl fall");
    // The limit changes only from a bus write.
    AST_OC_WRITE: assert property ($changed(overcurrentLimit) |-> $past(scl))
        else $error("limit changed without write");
    // Mode changes only after a write or a preset pin change.
    AST_PWM_CAUSE: assert property ($changed(forcedPwm) |-> $past(scl, 2) ||
        ($past(presetSelectPin) != $past(presetSelectPin, 2)))
        else $error("mode changed without cause");
    // Main scenarios reached.
    cover property ($rose(convEnable));
    cover property ($fell(protLatched));
    cover property ($changed(voutBank));
endmodule

bind vpec_core vpec_core_checker chk (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .presetSelectPin(presetSelectPin), .enablePin(enablePin), .protectFault(protectFault),
    .scl(scl), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .convEnable(convEnable),
    .forcedPwm(forcedPwm), .voutTarget(voutTarget), .voutBank(voutBank),
    .overcurrentLimit(overcurrentLimit), .protLatched(protLatched));

// ===== vpec_i2c_host.sv
`timescale 1ns/1ps
module vpec_i2c_host
    import vpec_pkg::*;
(
    // Clock and bus level.
    input wire logic core_clk,
    input wire logic sdaBus,
    // Host lines.
    output logic scl,
    output logic sdaDrv
);
    // A 2.5 us bit keeps the bus at the fast-mode ceiling.
    localparam int QTR = 125;
    // The bus idles released.
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Waits a quarter bit.
    task automatic q();
        repeat (QTR) @(posedge core_clk);
    endtask
    // Start is (1,0) and stop is (0,1): SDA moves while SCL is high.
    task automatic cond(input logic s0, input logic s1);
        sdaDrv <= s0;
        q();
        scl <= 1'b1;
        q();
        sdaDrv <= s1;
        q();
        scl <= s1;
        q();
    endtask
    // Data is set while SCL is low and sampled mid-way through SCL high.
    task automatic bit_io(input logic tx, output logic rx);
        sdaDrv <= tx;
        q();
        scl <= 1'b1;
        q();
        rx = sdaBus;
        q();
        scl <= 1'b0;
        q();
    endtask
    // A byte goes MSB first, then the acknowledge bit.
    task automatic byte_io(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx,
        output logic ackRx);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ackTx, ackRx);
    endtask
    // One-byte write, or a read through a repeated start ended by a NACK.
    task automatic access(input logic rd, input logic [7:0] ptr, input logic [7:0] wd,
        output logic [7:0] rdat, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        cond(1'b1, 1'b0);
        byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(ptr, 1'b1, rx, a1);
        a2 = 1'b0;
        if (rd)
        begin
            cond(1'b1, 1'b0);
            byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
        end
        byte_io(rd ? 8'hFF : wd, 1'b1, rdat, a3);
        cond(1'b0, 1'b1);
        ok = !(a0 | a1 | a2 | (a3 & !rd));
    endtask
endmodule

// ===== vpec_core_tb_top.sv
`timescale 1ns/1ps
module vpec_core_tb_top
    import vpec_pkg::*;
;
    // Pins and bench state.
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic presetSelectPin = 1'b0;
    logic enablePin = 1'b1;
    logic protectFault = 1'b0;
    logic scl, sdaDrv, sdaOut, sdaOe_b, convEnable, forcedPwm, protLatched, ok;
    logic [6:0] voutTarget;
    logic [1:0] voutBank;
    logic [7:0] overcurrentLimit, rdData;
    int fail_count = 0;
    int n_compared = 0;
    // The pull-up holds SDA high unless a party pulls it low.
    wire logic sdaBus = sdaDrv & (sdaOe_b | sdaOut);
    always #2.5 core_clk = ~core_clk;
    vpec_core dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
        .presetSelectPin(presetSelectPin), .enablePin(enablePin), .protectFault(protectFault),
        .scl(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .convEnable(convEnable),
        .forcedPwm(forcedPwm), .voutTarget(voutTarget), .voutBank(voutBank),
        .overcurrentLimit(overcurrentLimit), .protLatched(protLatched));
    vpec_i2c_host host (.core_clk(core_clk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));
    // Counts a comparison and reports a mismatch.
    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Lets edges pass, then samples settled outputs.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        step(3);
        cmp("convEnable", 8'h01, 8'(convEnable));
        cmp("voutTarget", 8'h40, 8'(voutTarget));
        cmp("voutBank", 8'h01, 8'(voutBank));
        cmp("ocLimit", RST_OC_LEVEL, overcurrentLimit);
        @(posedge core_clk);
        presetSelectPin <= 1'b1;
        step(2);
        cmp("voutTarget", 8'h7F, 8'(voutTarget));
        cmp("voutBank", 8'h02, 8'(voutBank));
        @(posedge core_clk);
        protectFault <= 1'b1;
        @(posedge core_clk);
        protectFault <= 1'b0;
        step(3);
        cmp("protLatched", 8'h01, 8'(protLatched));
        cmp("convEnable", 8'h00, 8'(convEnable));
        @(posedge core_clk);
        enablePin <= 1'b0;
        step(3);
        cmp("protLatched", 8'h00, 8'(protLatched));
        host.access(1'b0, REG_HIGH_PRESET, 8'h7E, rdData, ok);
        cmp("wrAck", 8'h01, 8'(ok));
        host.access(1'b0, REG_PWM_MODE, 8'h02, rdData, ok);
        host.access(1'b1, REG_HIGH_PRESET, 8'h00, rdData, ok);
        step(1);
        cmp("rdHigh", 8'h7E, rdData);
        cmp("voutTarget", 8'h7E, 8'(voutTarget));
        cmp("forcedPwm", 8'h01, 8'(forcedPwm));
        @(posedge core_clk);
        enablePin <= 1'b1;
        step(3);
        cmp("convEnable", 8'h00, 8'(convEnable));
        @(posedge core_clk);
        presetSelectPin <= 1'b0;
        step(2);
        cmp("convEnable", 8'h01, 8'(convEnable));
        cmp("forcedPwm", 8'h00, 8'(forcedPwm));
        cmp("voutTarget", 8'h40, 8'(voutTarget));
        @(posedge core_clk);
        presetSelectPin <= 1'b1;
        step(2);
        cmp("voutTarget", 8'h7E, 8'(voutTarget));
        // A software write moves the over-current level output.
        host.access(1'b0, REG_OC_LEVEL, 8'h0B, rdData, ok);
        step(2);
        cmp("ocLimit", 8'h0B, overcurrentLimit);
        // A lowered upper limit clamps the high preset code after a bank jump.
        host.access(1'b0, REG_VMAX, 8'h50, rdData, ok);
        cmp("wrAck", 8'h01, 8'(ok));
        @(posedge core_clk);
        presetSelectPin <= 1'b0;
        step(2);
        cmp("voutTarget", 8'h40, 8'(voutTarget));
        @(posedge core_clk);
        presetSelectPin <= 1'b1;
        step(2);
        cmp("voutTarget", 8'h50, 8'(voutTarget));
        complete_run();
    end
    // Cuts a hang short well after the expected run time.
    initial
    begin
        #450us;
        fail_count++;
        complete_run();
    end
endmodule
